//--- shared/sbt_map.svh
// constants for the sweep and burst trigger control block
// assumes a 100 MHz clock and an APB slave with 32-bit data
// Notes on behaviour
// - source is immediate, external or bus; defaults immediate; readable back
// - immediate source with sweep or burst enabled runs continuously
// - external source, not gated: each configured pin edge while idle starts exactly one run
// - bus source: each software trigger while idle starts exactly one run
// - waiting lamp lit while armed and waiting for a bus trigger
// - combined waveform combined_waveform_a command forces the source to immediate
// - wait command stalls later commands until pending runs finish
// - run finished answers completion query with 1, or sets event bit 0
// - generic trigger starts a run whatever the source
// - common trigger starts a run only with the bus source
// - triggered runs wait a programmable delay, 0 to 85 s, default 0
// - input edge selects rising or falling pin edge; default rising
// - gate polarity selects high or low as gate true; default high
// - enabled marker output drives configured edge at each run start
// - immediate source: marker is 50% square wave of programmed period
// - selecting external source forces the marker output off
// - bus source: one marker pulse longer than 1 us per run
// - marker enable defaults off; reads 0 off, 1 on
// - external edges during a run in progress are ignored
`ifndef SBT_MAP_SVH
`define SBT_MAP_SVH

// ==========================================================
// register byte offsets
`define SBT_OFS_CTRL      8'h00
`define SBT_OFS_DELAY     8'h04
`define SBT_OFS_PERIOD    8'h08
`define SBT_OFS_CMD       8'h0C
`define SBT_OFS_STATUS    8'h10
`define SBT_OFS_OPCQ      8'h14

// ==========================================================
// control register fields
`define SBT_CTRL_SRC_LO   0
`define SBT_CTRL_SRC_HI   1
`define SBT_CTRL_INEDGE   2
`define SBT_CTRL_GATEPOL  3
`define SBT_CTRL_MKEDGE   4
`define SBT_CTRL_MKEN     5
`define SBT_CTRL_SWEEPEN  6
`define SBT_CTRL_BURSTEN  7
`define SBT_CTRL_GATED    8

// command register fields
`define SBT_CMD_TRIG      0
`define SBT_CMD_COMTRIG   1
`define SBT_CMD_COMBINED_WAVEFORM_A     2
`define SBT_CMD_OPC       3
`define SBT_CMD_WAIT      4

// status register fields
`define SBT_ST_OPC        0
`define SBT_ST_BUSWAIT    1
`define SBT_ST_PENDING    2
`define SBT_ST_WAITHOLD   3
`define SBT_ST_GATE       4

// ==========================================================
// reset values
`define SBT_RST_DELAY     27'h0000000
`define SBT_RST_PERIOD    27'h00003E8

// ==========================================================
// timing
`define SBT_CLK_NS        10
`define SBT_USEC_NS       1000
`define SBT_USEC_CYC      (`SBT_USEC_NS / `SBT_CLK_NS)
`define SBT_MARK_MIN_NS   1000
`define SBT_MARK_CYC      ((`SBT_MARK_MIN_NS / `SBT_CLK_NS) + 1)
`define SBT_DELAY_MAX_S   85
`define SBT_DELAY_MAX_US  (`SBT_DELAY_MAX_S * 1000000)

`endif

//--- shared/sbt_pkg.sv
// types for the sweep and burst trigger control block
// assumes nothing beyond the constants header
`default_nettype none
package sbt_pkg;

	// ==========================================================
	// trigger source codes
	typedef enum logic [1:0] {
		SRC_IMMEDIATE = 2'h0,
		SRC_EXTERNAL  = 2'h1,
		SRC_BUS       = 2'h2
	} sbt_src_e;

	// ==========================================================
	// run sequencer states
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_DELAY = 4'b0010,
		ST_START = 4'b0100,
		ST_RUN   = 4'b1000
	} sbt_state_e;

	typedef logic [26:0] sbt_usec_t;

endpackage
`default_nettype wire

//--- logic/sbt_trigger_ctrl.sv
// trigger control for the sweep and burst engines, APB register slave
// assumes the run engine pulses runDone on clk when a run ends
`timescale 1ns/10ps
`default_nettype none
`include "sbt_map.svh"

module sbt_trigger_ctrl (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        trigIn,
	output logic             markerOut,
	output logic             markerDriveN,
	output logic             runStart,
	input  wire logic        runDone,
	output logic             busWaitLamp,
	output logic             gateOpen
);
	import sbt_pkg::*;

	// ==========================================================
	// state
	sbt_src_e         srcSel_reg;
	logic             inEdgeNeg_reg;
	logic             gateInv_reg;
	logic             mkEdgeNeg_reg;
	logic             mkEnable_reg;
	logic             sweepEn_reg;
	logic             burstEn_reg;
	logic             gated_reg;
	sbt_usec_t        delay_reg;
	sbt_usec_t        period_reg;
	sbt_state_e       state_reg;
	sbt_state_e       state_next;
	sbt_usec_t        delayCnt_reg;
	sbt_usec_t        periodCnt_reg;
	logic             immRunning_reg;
	logic [7:0]       pulseCnt_reg;
	logic [6:0]       usecDiv_reg;
	logic             usecTick;
	logic             trigMeta_reg;
	logic             trigSync_reg;
	logic             trigPrev_reg;
	logic             waitHold_reg;
	logic             opcArmed_reg;
	logic             opcEvent_reg;
	logic [31:0]      prdata_reg;
	logic             markerOut_reg;
	logic             markerDriveN_reg;

	// ==========================================================
	// bus decode
	logic             setup;
	logic             stall;
	logic             accessDone;
	logic             wrDone;
	logic             hitCtrl;
	logic             hitDelay;
	logic             hitPeriod;
	logic             hitCmd;
	logic             hitStatus;
	logic             hitOpcq;
	logic             mapped;
	logic [31:0]      rdMux;
	logic [31:0]      ctrlView;
	logic [31:0]      statusView;

	// run control
	logic             enabled;
	logic             pending;
	logic             pinRise;
	logic             pinFall;
	logic             pinEdge;
	logic             extTrig;
	logic             genTrig;
	logic             comTrig;
	logic             trigAccepted;
	logic             immDue;
	logic             runFinished;
	logic             markerActive;
	logic             markerAllowed;
	logic             cmdTrig;
	logic             cmdCom;
	logic             cmdApply;
	logic             cmdOpc;
	logic             cmdWait;
	logic             opcClear;
	sbt_src_e         wrSrc;
	sbt_usec_t        wrUsec;

	// address decode and handshake
	assign hitCtrl    = (paddr == `SBT_OFS_CTRL);
	assign hitDelay   = (paddr == `SBT_OFS_DELAY);
	assign hitPeriod  = (paddr == `SBT_OFS_PERIOD);
	assign hitCmd     = (paddr == `SBT_OFS_CMD);
	assign hitStatus  = (paddr == `SBT_OFS_STATUS);
	assign hitOpcq    = (paddr == `SBT_OFS_OPCQ);
	assign mapped     = hitCtrl | hitDelay | hitPeriod | hitCmd | hitStatus | hitOpcq;
	assign setup      = psel & ~penable;
	// later accesses wait for pending runs after a wait; completion query waits too
	assign stall      = (waitHold_reg & pending) | (hitOpcq & ~pwrite & pending);
	assign pready     = psel & penable & ~stall;
	assign pslverr    = psel & penable & ~stall & ~mapped;
	assign accessDone = psel & penable & ~stall;
	assign wrDone     = accessDone & pwrite & mapped;
	assign prdata     = prdata_reg;

	// write strobes of the command register and of the status event clear
	assign cmdTrig  = wrDone & hitCmd & pwdata[`SBT_CMD_TRIG];
	assign cmdCom   = wrDone & hitCmd & pwdata[`SBT_CMD_COMTRIG];
	assign cmdApply = wrDone & hitCmd & pwdata[`SBT_CMD_COMBINED_WAVEFORM_A];
	assign cmdOpc   = wrDone & hitCmd & pwdata[`SBT_CMD_OPC];
	assign cmdWait  = wrDone & hitCmd & pwdata[`SBT_CMD_WAIT];
	assign opcClear = wrDone & hitStatus & pwdata[`SBT_ST_OPC];

	// written fields, delay clamped to its range
	assign wrSrc  = sbt_src_e'(pwdata[`SBT_CTRL_SRC_HI:`SBT_CTRL_SRC_LO]);
	assign wrUsec = (pwdata[26:0] > 27'(`SBT_DELAY_MAX_US)) ?
		27'(`SBT_DELAY_MAX_US) : pwdata[26:0];

	// read views
	assign ctrlView = {23'h000000, gated_reg, burstEn_reg, sweepEn_reg, mkEnable_reg,
		mkEdgeNeg_reg, gateInv_reg, inEdgeNeg_reg, srcSel_reg};
	assign statusView = {27'h0000000, gateOpen, waitHold_reg, pending, busWaitLamp,
		opcEvent_reg};
	assign rdMux = hitCtrl   ? ctrlView :
		hitDelay  ? {5'h00, delay_reg} :
		hitPeriod ? {5'h00, period_reg} :
		hitStatus ? statusView :
		hitOpcq   ? 32'h00000001 : 32'h00000000;

	// read data captured in the setup cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			prdata_reg <= 32'h00000000;
		end else if (setup) begin
			prdata_reg <= pwrite ? 32'h00000000 : rdMux;
		end
	end

	// ==========================================================
	// configuration registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			srcSel_reg    <= SRC_IMMEDIATE;
			inEdgeNeg_reg <= 1'b0;
			gateInv_reg   <= 1'b0;
			mkEdgeNeg_reg <= 1'b0;
			mkEnable_reg  <= 1'b0;
			sweepEn_reg   <= 1'b0;
			burstEn_reg   <= 1'b0;
			gated_reg     <= 1'b0;
		end else if (cmdApply) begin
			srcSel_reg <= SRC_IMMEDIATE;
		end else if (wrDone & hitCtrl) begin
			if (wrSrc != 2'h3) begin
				srcSel_reg <= wrSrc;
			end
			inEdgeNeg_reg <= pwdata[`SBT_CTRL_INEDGE];
			gateInv_reg   <= pwdata[`SBT_CTRL_GATEPOL];
			mkEdgeNeg_reg <= pwdata[`SBT_CTRL_MKEDGE];
			mkEnable_reg  <= pwdata[`SBT_CTRL_MKEN] & (wrSrc != SRC_EXTERNAL);
			sweepEn_reg   <= pwdata[`SBT_CTRL_SWEEPEN];
			burstEn_reg   <= pwdata[`SBT_CTRL_BURSTEN];
			gated_reg     <= pwdata[`SBT_CTRL_GATED];
		end
	end

	// delay and period in microseconds
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			delay_reg  <= `SBT_RST_DELAY;
			period_reg <= `SBT_RST_PERIOD;
		end else if (wrDone & hitDelay) begin
			delay_reg <= wrUsec;
		end else if (wrDone & hitPeriod) begin
			period_reg <= (pwdata[26:0] == 27'h0000000) ? 27'h0000001 : pwdata[26:0];
		end
	end

	// ==========================================================
	// microsecond enable pulse
	assign usecTick = (usecDiv_reg == 7'(`SBT_USEC_CYC - 1));

	always_ff @(posedge clk) begin
		if (sys_rst | usecTick) begin
			usecDiv_reg <= 7'h00;
		end else begin
			usecDiv_reg <= usecDiv_reg + 7'h01;
		end
	end

	// ==========================================================
	// trigger pin synchroniser and edge detect
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			trigMeta_reg <= 1'b0;
			trigSync_reg <= 1'b0;
			trigPrev_reg <= 1'b0;
		end else begin
			trigMeta_reg <= trigIn;
			trigSync_reg <= trigMeta_reg;
			trigPrev_reg <= trigSync_reg;
		end
	end

	assign pinRise = trigSync_reg & ~trigPrev_reg;
	assign pinFall = ~trigSync_reg & trigPrev_reg;
	assign pinEdge = inEdgeNeg_reg ? pinFall : pinRise;
	// gate level for gated bursts, the engine reads it
	assign gateOpen = gated_reg & (srcSel_reg == SRC_EXTERNAL) &
		(trigSync_reg ^ gateInv_reg);

	// ==========================================================
	// trigger qualification
	assign enabled  = sweepEn_reg | burstEn_reg;
	assign extTrig  = (srcSel_reg == SRC_EXTERNAL) & ~gated_reg & pinEdge;
	assign genTrig  = cmdTrig;
	assign comTrig  = cmdCom & (srcSel_reg == SRC_BUS);
	// edges outside the idle state are dropped
	assign trigAccepted = enabled & (state_reg == ST_IDLE) &
		(extTrig | genTrig | comTrig);
	assign immDue = enabled & (srcSel_reg == SRC_IMMEDIATE) &
		(~immRunning_reg | (periodCnt_reg >= period_reg));
	assign pending = (state_reg != ST_IDLE);
	assign runFinished = (state_reg == ST_RUN) & runDone;
	assign busWaitLamp = enabled & (srcSel_reg == SRC_BUS) &
		(state_reg == ST_IDLE);

	// sequencer next state
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (trigAccepted) begin
					state_next = (delay_reg == 27'h0000000) ? ST_START : ST_DELAY;
				end else if (immDue) begin
					state_next = ST_START;
				end
			end
			ST_DELAY: begin
				if (usecTick & (delayCnt_reg <= 27'h0000001)) begin
					state_next = ST_START;
				end
			end
			ST_START: begin
				state_next = ST_RUN;
			end
			ST_RUN: begin
				if (runDone) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// sequencer state and delay countdown
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_reg    <= ST_IDLE;
			delayCnt_reg <= 27'h0000000;
		end else begin
			state_reg <= state_next;
			if (state_reg == ST_IDLE) begin
				delayCnt_reg <= delay_reg;
			end else if ((state_reg == ST_DELAY) & usecTick) begin
				delayCnt_reg <= delayCnt_reg - 27'h0000001;
			end
		end
	end

	// one start pulse per accepted trigger
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			runStart <= 1'b0;
		end else begin
			runStart <= (state_reg == ST_START);
		end
	end

	// ==========================================================
	// immediate period timer, restarted at each run start
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			periodCnt_reg  <= 27'h0000000;
			immRunning_reg <= 1'b0;
		end else if (~enabled | (srcSel_reg != SRC_IMMEDIATE)) begin
			periodCnt_reg  <= 27'h0000000;
			immRunning_reg <= 1'b0;
		end else if (state_reg == ST_START) begin
			periodCnt_reg  <= 27'h0000000;
			immRunning_reg <= 1'b1;
		end else if (usecTick & (periodCnt_reg < period_reg)) begin
			periodCnt_reg <= periodCnt_reg + 27'h0000001;
		end
	end

	// bus pulse width counter
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pulseCnt_reg <= 8'h00;
		end else if ((state_reg == ST_START) & (srcSel_reg == SRC_BUS)) begin
			pulseCnt_reg <= 8'(`SBT_MARK_CYC);
		end else if (pulseCnt_reg != 8'h00) begin
			pulseCnt_reg <= pulseCnt_reg - 8'h01;
		end
	end

	// ==========================================================
	// marker output
	assign markerAllowed = mkEnable_reg & enabled & (srcSel_reg != SRC_EXTERNAL);
	assign markerActive =
		((srcSel_reg == SRC_IMMEDIATE) & immRunning_reg &
			({periodCnt_reg, 1'b0} < {1'b0, period_reg})) |
		((srcSel_reg == SRC_BUS) & (pulseCnt_reg != 8'h00));

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			markerOut_reg    <= 1'b0;
			markerDriveN_reg <= 1'b1;
		end else begin
			markerOut_reg    <= (markerAllowed & markerActive) ^ mkEdgeNeg_reg;
			markerDriveN_reg <= ~markerAllowed;
		end
	end

	assign markerOut    = markerOut_reg;
	assign markerDriveN = markerDriveN_reg;

	// ==========================================================
	// wait hold and operation complete event
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			waitHold_reg    <= 1'b0;
			opcArmed_reg    <= 1'b0;
			opcEvent_reg    <= 1'b0;
		end else begin
			if (cmdWait) begin
				waitHold_reg <= 1'b1;
			end else if (~pending) begin
				waitHold_reg <= 1'b0;
			end
			if (cmdOpc & pending) begin
				opcArmed_reg <= 1'b1;
			end else if (runFinished) begin
				opcArmed_reg <= 1'b0;
			end
			// set beats clear in the same cycle
			opcEvent_reg <= (runFinished & opcArmed_reg) | (cmdOpc & ~pending) |
				(opcEvent_reg & ~opcClear);
		end
	end

endmodule // sbt_trigger_ctrl
`default_nettype wire

//--- verification/sbt_engine_model.sv
// model of the run engine and of the outside trigger source
// assumes runStart is a one-cycle pulse on clk
`timescale 1ns/10ps
`default_nettype none

module sbt_engine_model (
	input	wire logic		clk,
	input	wire logic [15:0]	doneLat,
	input	wire logic		runStart,
	output	logic			runDone,
	output	logic			trigIn
);
	logic [15:0]	left;

	// ==========================================================
	// run engine: ends each run doneLat cycles after its start
	always @(posedge clk) begin
		runDone <= left == 16'h0001;
		if (runStart)
			left <= doneLat;
		else if (left != 16'h0000)
			left <= left - 16'h0001;
	end

	// outside source: drives the shared connector after an edge
	task automatic setPin(input logic v);
		@(posedge clk);
		trigIn <= v;
	endtask

	// idle engine and low pin at start
	initial begin
		left = 16'h0000;
		runDone = 1'b0;
		trigIn = 1'b0;
	end
endmodule // sbt_engine_model
`default_nettype wire

//--- verification/sbt_trigger_checker.sv
// port assertions for the trigger control block
// assumes a bind into sbt_trigger_ctrl
`timescale 1ns/10ps
`default_nettype none
`include "sbt_map.svh"

module sbt_trigger_checker
	import sbt_pkg::*;
(
	input	wire logic		clk,
	input	wire logic		sys_rst,
	input	wire logic		psel,
	input	wire logic		penable,
	input	wire logic		pwrite,
	input	wire logic [7:0]	paddr,
	input	wire logic [31:0]	pwdata,
	input	wire logic		pready,
	input	wire logic [31:0]	prdata,
	input	wire logic		pslverr,
	input	wire logic		trigIn,
	input	wire logic		markerOut,
	input	wire logic		markerDriveN,
	input	wire logic		runStart,
	input	wire logic		runDone,
	input	wire logic		busWaitLamp,
	input	wire logic		gateOpen
);
	// ==========================================================
	// shadow of the programmed state and run activity
	logic [8:0]	ctrlSh;
	logic		dlyZero, dlyOk, busy;
	logic [7:0]	quiet, hiCnt;
	wire		take = psel & penable & pready & pwrite;
	wire		wrCtrl = take & (paddr == `SBT_OFS_CTRL);
	wire		wrDly = take & (paddr == `SBT_OFS_DELAY);
	wire		wrCmd = take & (paddr == `SBT_OFS_CMD);
	wire		combined_waveform_a = wrCmd & pwdata[2];
	wire		rdOpc = psel & penable & !pwrite & (paddr == `SBT_OFS_OPCQ);
	wire		runOn = ctrlSh[7:6] != 2'h0;
	wire [1:0]	src = ctrlSh[1:0];

	// track writes, delays in flight and marker high time
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrlSh <= 9'h000;
			dlyZero <= 1'b1;
			dlyOk <= 1'b1;
			busy <= 1'b0;
			quiet <= 8'h00;
			hiCnt <= 8'h00;
		end else begin
			if (wrCtrl && pwdata[1:0] != 2'h3)
				ctrlSh <= {pwdata[8:6], pwdata[5] & (pwdata[1:0] != 2'h1), pwdata[4:0]};
			else if (combined_waveform_a)
				ctrlSh[1:0] <= 2'h0;
			if (wrDly)
				dlyZero <= pwdata[26:0] == 27'h0000000;
			dlyOk <= (wrDly && pwdata[26:0] != 27'h0000000) ? 1'b0 : dlyOk | (runStart & dlyZero);
			busy <= runStart | (busy & !runDone);
			quiet <= (wrCtrl | combined_waveform_a) ? 8'h00 : quiet + {7'h00, quiet != 8'hFF};
			hiCnt <= markerOut ? hiCnt + {7'h00, hiCnt != 8'hFF} : 8'h00;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	// ==========================================================
	// assertions
	a_start_pulse: assert property (runStart |=> !runStart)
		else $error("run start wider than one cycle");
	a_bus_start: assert property (wrCmd && pwdata[1:0] != 2'h0 && !pwdata[2]
		&& src == SRC_BUS && runOn && dlyOk && dlyZero && !busy && !runStart
		&& quiet > 8'h05 |-> ##2 runStart) else $error("bus trigger did not start a run");
	a_common_ignored: assert property (wrCmd && pwdata[2:0] == 3'h2 && ctrlSh[8]
		&& src == SRC_EXTERNAL && dlyOk && dlyZero && quiet > 8'h05 |-> ##2 !runStart)
		else $error("common trigger started a run off the bus source");
	a_lamp_bus: assert property (busWaitLamp |-> src == SRC_BUS && !busy)
		else $error("waiting lamp lit outside bus wait");
	a_drive_off: assert property ($past(src) == SRC_EXTERNAL || !$past(ctrlSh[5])
		|| !$past(runOn) |-> markerDriveN) else $error("marker driven while off");
	a_bus_width: assert property ($fell(markerOut) && src == SRC_BUS && !ctrlSh[4]
		&& quiet > 8'h6E |-> hiCnt > 8'h64) else $error("bus marker pulse too short");
	a_opc_stall: assert property (rdOpc && busy |-> !pready)
		else $error("completion query answered while a run is pending");
	a_opc_one: assert property (rdOpc && pready |-> prdata == 32'h00000001)
		else $error("completion query did not return one");
	a_gate_level: assert property (ctrlSh[8] && src == SRC_EXTERNAL && quiet > 8'h03
		|-> gateOpen == ($past(trigIn, 2) ^ ctrlSh[3])) else $error("gate level wrong");
	a_err_unmapped: assert property (psel && penable && pready && paddr > `SBT_OFS_OPCQ
		|-> pslverr) else $error("unmapped access answered without error");
endmodule // sbt_trigger_checker

bind sbt_trigger_ctrl sbt_trigger_checker CHK (.clk(clk), .sys_rst(sys_rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.prdata(prdata), .pslverr(pslverr), .trigIn(trigIn), .markerOut(markerOut),
	.markerDriveN(markerDriveN), .runStart(runStart), .runDone(runDone),
	.busWaitLamp(busWaitLamp), .gateOpen(gateOpen));
`default_nettype wire

//--- verification/testbench.sv
// self-checking bench for the trigger control block
// assumes the engine model and the checker compile first
`timescale 1ns/10ps
`default_nettype none
`include "sbt_map.svh"

module testbench;
	logic		clk, sys_rst, psel, penable, pwrite, pready, pslverr, er;
	logic		trigIn, markerOut, markerDriveN, runStart, runDone, busWaitLamp, gateOpen;
	logic [7:0]	paddr;
	logic [31:0]	pwdata, prdata, rd;
	logic [15:0]	lat;
	int		miscompares, num_checks, runs, cyc;

	sbt_trigger_ctrl DUT (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .trigIn(trigIn), .markerOut(markerOut), .markerDriveN(markerDriveN),
		.runStart(runStart), .runDone(runDone), .busWaitLamp(busWaitLamp), .gateOpen(gateOpen));
	sbt_engine_model ENG (.clk(clk), .doneLat(lat), .runStart(runStart), .runDone(runDone),
		.trigIn(trigIn));

	// ==========================================================
	// clock, run counter and hang limit
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (runStart === 1'b1)
			runs <= runs + 1;
		if (cyc == 30000) begin
			miscompares++;
			conclude();
		end
	end

	// ==========================================================
	// shared tasks
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic waitc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// one apb transfer, then one idle cycle
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// answer taken at the rising edge that sees pready high
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ==========================================================
	// scenarios
	task automatic t_defaults;
		apb(1'b0, `SBT_OFS_CTRL, 32'h0);
		chk("ctrl", rd, 32'h0);
		apb(1'b0, `SBT_OFS_DELAY, 32'h0);
		chk("delay", rd, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped", 32'(er), 32'h1);
		$display("test defaults done");
	endtask
	task automatic t_bus;
		int r0;
		lat = 16'h0032;
		apb(1'b1, `SBT_OFS_CTRL, 32'hA2);
		waitc(20);
		chk("lamp", 32'(busWaitLamp), 32'h1);
		r0 = runs;
		apb(1'b1, `SBT_OFS_CMD, 32'h0A);
		waitc(5);
		chk("lamp", 32'(busWaitLamp), 32'h0);
		apb(1'b0, `SBT_OFS_OPCQ, 32'h0);
		chk("opcq", rd, 32'h1);
		apb(1'b0, `SBT_OFS_STATUS, 32'h0);
		chk("opc", 32'(rd[0]), 32'h1);
		chk("runs", 32'(runs - r0), 32'h1);
		apb(1'b1, `SBT_OFS_STATUS, 32'h1);
		apb(1'b1, `SBT_OFS_CMD, 32'h12);
		apb(1'b1, `SBT_OFS_CMD, 32'h02);
		apb(1'b1, `SBT_OFS_CMD, 32'h08);
		apb(1'b0, `SBT_OFS_STATUS, 32'h0);
		chk("opc", 32'(rd[0]), 32'h0);
		waitc(80);
		apb(1'b0, `SBT_OFS_STATUS, 32'h0);
		chk("opc", 32'(rd[0]), 32'h1);
		chk("runs", 32'(runs - r0), 32'h3);
		$display("test bus done");
	endtask
	task automatic t_ext;
		int r0;
		lat = 16'h012C;
		apb(1'b1, `SBT_OFS_CTRL, 32'hA1);
		apb(1'b0, `SBT_OFS_CTRL, 32'h0);
		chk("ctrl", rd, 32'h81);
		chk("drive", 32'(markerDriveN), 32'h1);
		r0 = runs;
		ENG.setPin(1'b1);
		waitc(10);
		ENG.setPin(1'b0);
		waitc(10);
		ENG.setPin(1'b1);
		ENG.setPin(1'b0);
		waitc(400);
		chk("runs", 32'(runs - r0), 32'h1);
		lat = 16'h0014;
		apb(1'b1, `SBT_OFS_CTRL, 32'h85);
		ENG.setPin(1'b1);
		waitc(10);
		chk("runs", 32'(runs - r0), 32'h1);
		ENG.setPin(1'b0);
		waitc(40);
		chk("runs", 32'(runs - r0), 32'h2);
		apb(1'b1, `SBT_OFS_CMD, 32'h1);
		waitc(40);
		chk("runs", 32'(runs - r0), 32'h3);
		apb(1'b1, `SBT_OFS_CTRL, 32'h181);
		waitc(8);
		apb(1'b1, `SBT_OFS_CMD, 32'h2);
		waitc(10);
		chk("runs", 32'(runs - r0), 32'h3);
		ENG.setPin(1'b1);
		waitc(5);
		chk("gate", 32'(gateOpen), 32'h1);
		apb(1'b1, `SBT_OFS_CTRL, 32'h189);
		waitc(5);
		chk("gate", 32'(gateOpen), 32'h0);
		ENG.setPin(1'b0);
		$display("test ext done");
	endtask
	task automatic t_imm;
		int r0, hi;
		apb(1'b1, `SBT_OFS_CTRL, 32'hA2);
		apb(1'b1, `SBT_OFS_PERIOD, 32'h2);
		apb(1'b1, `SBT_OFS_CMD, 32'h4);
		apb(1'b0, `SBT_OFS_CTRL, 32'h0);
		chk("src", 32'(rd[1:0]), 32'h0);
		chk("mken", 32'(rd[5]), 32'h1);
		r0 = runs;
		hi = 0;
		repeat (1000) begin
			@(posedge clk);
			hi += (markerOut === 1'b1);
		end
		chk("runs", 32'(runs - r0 >= 4), 32'h1);
		chk("duty", 32'(hi > 450 && hi < 550), 32'h1);
		chk("drive", 32'(markerDriveN), 32'h0);
		// falling marker edge: output idles high, low in the first half
		apb(1'b1, `SBT_OFS_CTRL, 32'hB0);
		hi = 0;
		repeat (400) begin
			@(posedge clk);
			hi += (markerOut === 1'b1);
		end
		chk("edge", 32'(hi > 180 && hi < 220), 32'h1);
		$display("test immediate done");
	endtask
	task automatic t_delay;
		int r0, t0;
		apb(1'b1, `SBT_OFS_CTRL, 32'h42);
		apb(1'b1, `SBT_OFS_DELAY, 32'h3);
		waitc(30);
		r0 = runs;
		t0 = cyc;
		apb(1'b1, `SBT_OFS_CMD, 32'h1);
		while (runs == r0)
			@(posedge clk);
		chk("wait", 32'(cyc - t0 > 200 && cyc - t0 < 320), 32'h1);
		apb(1'b1, `SBT_OFS_DELAY, 32'hFFFFFFFF);
		apb(1'b0, `SBT_OFS_DELAY, 32'h0);
		chk("clamp", rd, 32'h0510FF40);
		$display("test delay done");
	endtask

	// ==========================================================
	// main sequence
	initial begin
		sys_rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		lat = 16'h0014;
		miscompares = 0;
		num_checks = 0;
		runs = 0;
		cyc = 0;
		waitc(20);
		sys_rst <= 1'b0;
		@(posedge clk);
		t_defaults();
		t_bus();
		t_ext();
		t_imm();
		t_delay();
		conclude();
	end
endmodule // testbench
`default_nettype wire
